// File: hw/evs_pkg.sv
// Constants shared by the excitation voltage supervision design files.
package evs_pkg;
    // Time base: one setting step is 5 ms at a 10 ns clock.
    localparam int CLK_PERIOD_NS = 10;
    localparam int STEP_NS       = 5_000_000;
    localparam int STEP_CYCLES   = (STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // Widths of settings and of measured quantities.
    localparam int SET_W  = 12;
    localparam int MEAS_W = 16;
    localparam int ADDR_W = 8;

    // Settings registers, byte offset = index * 4.
    localparam int IDX_CTRL      = 0;
    localparam int IDX_VDLY      = 1;
    localparam int IDX_VRATIO    = 2;
    localparam int IDX_IRATIO    = 3;
    localparam int IDX_IFLD_LVL  = 4;
    localparam int IDX_OVC_THR   = 5;
    localparam int IDX_OVC_DLY   = 6;
    localparam int IDX_OPN_DLY   = 7;
    localparam int IDX_OPN_HI    = 8;
    localparam int IDX_OPN_LO    = 9;
    localparam int CFG_COUNT     = 10;

    // Read-only registers.
    localparam logic [7:0] OFF_STATUS  = 8'h28;
    localparam logic [7:0] OFF_MON_U1  = 8'h2c;
    localparam logic [7:0] OFF_MON_U2  = 8'h30;
    localparam logic [7:0] OFF_MON_SUP = 8'h34;

    // Control bits.
    localparam int CTRL_SUP_EN = 0;
    localparam int CTRL_OVC_EN = 1;
    localparam int CTRL_OPN_EN = 2;

    // Status bits.
    localparam int ST_PHASE   = 0;
    localparam int ST_BLOCK   = 1;
    localparam int ST_ROUTE1  = 2;
    localparam int ST_ROUTE2  = 3;
    localparam int ST_ROUTE3  = 4;
    localparam int ST_SUP_ACT = 5;
    localparam int ST_MTRIP   = 6;
    localparam int ST_STRIP   = 7;
    localparam int ST_FCR     = 8;
    localparam int ST_OVC     = 9;
    localparam int ST_OPEN    = 10;
    localparam int ST_W       = 11;

    // Reset values in setting steps (5 ms, 0.005 or 0.01 units).
    localparam logic [SET_W-1:0] CFG_RST [0:CFG_COUNT-1] = '{
        12'h001, 12'h028, 12'h03c, 12'h03c, 12'h0c8,
        12'h064, 12'h258, 12'h258, 12'h064, 12'h00a};

    // Fixed levels in 0.01 p.u.; ratios in 0.005 steps.
    localparam logic signed [MEAS_W:0]   DIFF_MARGIN = 17'sh00014;
    localparam logic signed [MEAS_W-1:0] LEVEL_LOW   = 16'sh000a;
    localparam logic [SET_W-1:0]         HALF_RATIO  = 12'h064;
    localparam logic signed [31:0]       RATIO_SCALE = 32'sh000000c8;

    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// File: hw/evs_ratio_cmp.sv
// Compares a quotient of two signed quantities against a ratio setting.
`timescale 1ns/1ns
module evs_ratio_cmp
    import evs_pkg::*;
#(
    parameter int W = MEAS_W
) (
    input  wire logic signed [W-1:0]     num,
    input  wire logic signed [W-1:0]     den,
    input  wire logic        [SET_W-1:0] ratio,
    output logic                         gt,
    output logic                         lt
);
    logic signed [31:0] lhs;
    logic signed [31:0] rhs;

    // Cross-multiplied so no divider is needed; ratio is in 0.005 steps.
    assign lhs = 32'(num) * RATIO_SCALE;
    assign rhs = $signed(32'(ratio)) * 32'(den);
    assign gt  = lhs > rhs;
    assign lt  = lhs < rhs;
endmodule

// File: hw/evs_delay_timer.sv
// Delay timer that trips when its condition holds for the set step count.
`timescale 1ns/1ns
module evs_delay_timer
    import evs_pkg::*;
#(
    parameter int W = SET_W
) (
    input  wire logic         aclk,
    input  wire logic         aresetn,
    input  wire logic         tick,
    input  wire logic         cond,
    input  wire logic [W-1:0] delay,
    output logic              done
);
    logic [W-1:0] cnt_reg;
    logic         done_reg;

    // The count saturates at the delay, so a long hold never wraps.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cnt_reg <= '0;
        end else if (!cond) begin
            cnt_reg <= '0;
        end else if (tick && cnt_reg < delay) begin
            cnt_reg <= cnt_reg + 1'b1;
        end
    end

    // Trip output is registered and drops on the clock edge after the condition clears.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            done_reg <= 1'b0;
        end else begin
            done_reg <= cond && cnt_reg >= delay;
        end
    end

    assign done = done_reg;
endmodule

// File: hw/evs_supervision.sv
// Voltage supervision, field overcurrent and open field detection.
//
// The placing of the registers and the AXI4-Lite register port are this design's own decisions.
`timescale 1ns/1ns
module evs_supervision
    import evs_pkg::*;
#(
    parameter int TICK_CYCLES = STEP_CYCLES
) (
    input  wire logic                     aclk,
    input  wire logic                     aresetn,
    input  wire logic [ADDR_W-1:0]        s_axi_awaddr,
    input  wire logic                     s_axi_awvalid,
    output logic                          s_axi_awready,
    input  wire logic [31:0]              s_axi_wdata,
    input  wire logic [3:0]               s_axi_wstrb,
    input  wire logic                     s_axi_wvalid,
    output logic                          s_axi_wready,
    output logic [1:0]                    s_axi_bresp,
    output logic                          s_axi_bvalid,
    input  wire logic                     s_axi_bready,
    input  wire logic [ADDR_W-1:0]        s_axi_araddr,
    input  wire logic                     s_axi_arvalid,
    output logic                          s_axi_arready,
    output logic [31:0]                   s_axi_rdata,
    output logic [1:0]                    s_axi_rresp,
    output logic                          s_axi_rvalid,
    input  wire logic                     s_axi_rready,
    input  wire logic signed [MEAS_W-1:0] positive_sequence_voltage,
    input  wire logic signed [MEAS_W-1:0] negative_sequence_voltage,
    input  wire logic signed [MEAS_W-1:0] supply_voltage,
    input  wire logic signed [MEAS_W-1:0] pos_seq_current,
    input  wire logic signed [MEAS_W-1:0] neg_seq_current,
    input  wire logic signed [MEAS_W-1:0] field_current,
    input  wire logic signed [MEAS_W-1:0] control_signal,
    input  wire logic                     grid_on,
    input  wire logic                     volt_synced,
    input  wire logic                     exc_start,
    input  wire logic                     ifl_active,
    output logic                          to_field_current_regulation_mode,
    output logic                          meas_volt_fail,
    output logic                          supply_volt_fail,
    output logic                          field_ovc_trip,
    output logic                          rectifier_trip,
    output logic                          excitation_stop
);
    localparam int TICK_W = $clog2(TICK_CYCLES + 1);

    logic [SET_W-1:0]        cfg_reg [0:CFG_COUNT-1];
    logic                    aw_held_reg;
    logic [ADDR_W-1:0]       aw_addr_reg;
    logic                    w_held_reg;
    logic [31:0]             w_data_reg;
    logic [3:0]              w_strb_reg;
    logic                    bvalid_reg;
    logic [1:0]              bresp_reg;
    logic                    rvalid_reg;
    logic [31:0]             rdata_reg;
    logic [1:0]              rresp_reg;
    logic                    wr_go;
    logic                    wr_ok;
    logic [3:0]              wr_idx;
    logic [3:0]              rd_idx;
    logic [31:0]             rd_data;
    logic                    rd_ok;
    logic [TICK_W-1:0]       tick_cnt_reg;
    logic                    tick_reg;
    logic signed [MEAS_W-1:0] mon_u1_reg;
    logic signed [MEAS_W-1:0] mon_u2_reg;
    logic signed [MEAS_W-1:0] mon_sup_reg;
    logic                    fcr_reg;
    logic [ST_W-1:0]         status;
    logic                    sup_en;
    logic                    ovc_en;
    logic                    opn_en;
    logic                    phase_loss;
    logic                    blocked;
    logic                    vratio_gt;
    logic                    iratio_lt;
    logic                    route1;
    logic                    route2;
    logic                    route3;
    logic                    fld_over_lvl;
    logic signed [MEAS_W:0]  v_diff;
    logic                    supply_low;
    logic                    meas_low;
    logic                    meas_trip;
    logic                    sup_trip;
    logic                    ovc_cond;
    logic                    open_cond;
    logic                    ovc_trip;
    logic                    open_trip;

    // Write channel: address and data are caught in either order.
    assign s_axi_awready = !aw_held_reg && !bvalid_reg;
    assign s_axi_wready  = !w_held_reg && !bvalid_reg;
    assign wr_go         = aw_held_reg && w_held_reg && !bvalid_reg;
    assign wr_idx        = aw_addr_reg[5:2];
    assign wr_ok         = aw_addr_reg[1:0] == 2'h0
                        && aw_addr_reg < OFF_STATUS;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_reg <= 1'b0;
            aw_addr_reg <= '0;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_held_reg <= 1'b1;
            aw_addr_reg <= s_axi_awaddr;
        end else if (wr_go) begin
            aw_held_reg <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_held_reg <= 1'b0;
            w_data_reg <= '0;
            w_strb_reg <= '0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_held_reg <= 1'b1;
            w_data_reg <= s_axi_wdata;
            w_strb_reg <= s_axi_wstrb;
        end else if (wr_go) begin
            w_held_reg <= 1'b0;
        end
    end

    // Response is given one cycle after both halves are held.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid_reg <= 1'b0;
            bresp_reg  <= RESP_OKAY;
        end else if (wr_go) begin
            bvalid_reg <= 1'b1;
            bresp_reg  <= wr_ok ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_bready) begin
            bvalid_reg <= 1'b0;
        end
    end

    assign s_axi_bvalid = bvalid_reg;
    assign s_axi_bresp  = bresp_reg;

    // Settings store; lanes above bit 11 are ignored.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            for (int i = 0; i < CFG_COUNT; i++) begin
                cfg_reg[i] <= CFG_RST[i];
            end
        end else if (wr_go && wr_ok) begin
            if (w_strb_reg[0]) begin
                cfg_reg[wr_idx][7:0] <= w_data_reg[7:0];
            end
            if (w_strb_reg[1]) begin
                cfg_reg[wr_idx][11:8] <= w_data_reg[11:8];
            end
        end
    end

    // Read decode; misaligned or unmapped reads answer SLVERR and zero.
    assign rd_idx = s_axi_araddr[5:2];

    always_comb begin
        rd_data = 32'h0;
        rd_ok   = 1'b1;
        if (s_axi_araddr[1:0] != 2'h0) begin
            rd_ok = 1'b0;
        end else if (s_axi_araddr < OFF_STATUS) begin
            rd_data = {20'h0, cfg_reg[rd_idx]};
        end else if (s_axi_araddr == OFF_STATUS) begin
            rd_data = {21'h0, status};
        end else if (s_axi_araddr == OFF_MON_U1) begin
            rd_data = 32'(mon_u1_reg);
        end else if (s_axi_araddr == OFF_MON_U2) begin
            rd_data = 32'(mon_u2_reg);
        end else if (s_axi_araddr == OFF_MON_SUP) begin
            rd_data = 32'(mon_sup_reg);
        end else begin
            rd_ok = 1'b0;
        end
    end

    assign s_axi_arready = !rvalid_reg;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_reg <= 1'b0;
            rdata_reg  <= '0;
            rresp_reg  <= RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            rvalid_reg <= 1'b1;
            rdata_reg  <= rd_data;
            rresp_reg  <= rd_ok ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_rready) begin
            rvalid_reg <= 1'b0;
        end
    end

    assign s_axi_rvalid = rvalid_reg;
    assign s_axi_rdata  = rdata_reg;
    assign s_axi_rresp  = rresp_reg;

    // Monitors are sampled every cycle so a read sees one coherent value.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            mon_u1_reg  <= '0;
            mon_u2_reg  <= '0;
            mon_sup_reg <= '0;
        end else begin
            mon_u1_reg  <= positive_sequence_voltage;
            mon_u2_reg  <= negative_sequence_voltage;
            mon_sup_reg <= supply_voltage;
        end
    end

    // Step tick of 5 ms that paces every delay timer.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            tick_cnt_reg <= '0;
            tick_reg     <= 1'b0;
        end else if (tick_cnt_reg == TICK_W'(TICK_CYCLES - 1)) begin
            tick_cnt_reg <= '0;
            tick_reg     <= 1'b1;
        end else begin
            tick_cnt_reg <= tick_cnt_reg + 1'b1;
            tick_reg     <= 1'b0;
        end
    end

    assign sup_en = cfg_reg[IDX_CTRL][CTRL_SUP_EN];
    assign ovc_en = cfg_reg[IDX_CTRL][CTRL_OVC_EN];
    assign opn_en = cfg_reg[IDX_CTRL][CTRL_OPN_EN];

    // Sequence ratio checks: fixed half ratios and the two settings.
    evs_ratio_cmp u_phase (
        .num   (negative_sequence_voltage),
        .den   (positive_sequence_voltage),
        .ratio (HALF_RATIO),
        .gt    (phase_loss),
        .lt    ()
    );
    evs_ratio_cmp u_block (
        .num   (neg_seq_current),
        .den   (pos_seq_current),
        .ratio (HALF_RATIO),
        .gt    (blocked),
        .lt    ()
    );
    evs_ratio_cmp u_vratio (
        .num   (negative_sequence_voltage),
        .den   (positive_sequence_voltage),
        .ratio (cfg_reg[IDX_VRATIO]),
        .gt    (vratio_gt),
        .lt    ()
    );
    evs_ratio_cmp u_iratio (
        .num   (neg_seq_current),
        .den   (pos_seq_current),
        .ratio (cfg_reg[IDX_IRATIO]),
        .gt    (),
        .lt    (iratio_lt)
    );

    // Field current is in 0.01 units, its level in 0.005 steps.
    assign fld_over_lvl = $signed({field_current, 1'b0})
                        > $signed({5'h0, cfg_reg[IDX_IFLD_LVL]});
    assign v_diff = {positive_sequence_voltage[MEAS_W-1],
                     positive_sequence_voltage}
                  - {supply_voltage[MEAS_W-1], supply_voltage};

    // Activation routes of the measuring voltage supervision.
    assign route1 = sup_en && volt_synced && vratio_gt
                 && positive_sequence_voltage > LEVEL_LOW
                 && (iratio_lt || pos_seq_current < LEVEL_LOW);
    assign route2 = sup_en && exc_start && fld_over_lvl
                 && positive_sequence_voltage < LEVEL_LOW;
    assign route3 = sup_en && grid_on && v_diff < -DIFF_MARGIN;

    // A grid fault shows as current unbalance, so it vetoes both checks.
    assign meas_low = sup_en && !blocked
                   && (phase_loss || route1 || route2 || route3);
    assign supply_low = sup_en && grid_on && !blocked
                     && v_diff > DIFF_MARGIN;

    evs_delay_timer u_meas_tmr (
        .aclk    (aclk),
        .aresetn (aresetn),
        .tick    (tick_reg),
        .cond    (meas_low),
        .delay   (cfg_reg[IDX_VDLY]),
        .done    (meas_trip)
    );
    evs_delay_timer u_sup_tmr (
        .aclk    (aclk),
        .aresetn (aresetn),
        .tick    (tick_reg),
        .cond    (supply_low),
        .delay   (cfg_reg[IDX_VDLY]),
        .done    (sup_trip)
    );

    // Overcurrent relies on the instant limiter pinning the control low.
    assign ovc_cond = ovc_en && ifl_active
        && control_signal < $signed({4'h0, cfg_reg[IDX_OVC_THR]});
    assign open_cond = opn_en
        && control_signal > $signed({4'h0, cfg_reg[IDX_OPN_HI]})
        && field_current < $signed({4'h0, cfg_reg[IDX_OPN_LO]});

    evs_delay_timer u_ovc_tmr (
        .aclk    (aclk),
        .aresetn (aresetn),
        .tick    (tick_reg),
        .cond    (ovc_cond),
        .delay   (cfg_reg[IDX_OVC_DLY]),
        .done    (ovc_trip)
    );
    evs_delay_timer u_open_tmr (
        .aclk    (aclk),
        .aresetn (aresetn),
        .tick    (tick_reg),
        .cond    (open_cond),
        .delay   (cfg_reg[IDX_OPN_DLY]),
        .done    (open_trip)
    );

    // Transfer request follows either voltage trip one cycle later.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            fcr_reg <= 1'b0;
        end else begin
            fcr_reg <= meas_trip || sup_trip;
        end
    end

    assign to_field_current_regulation_mode = fcr_reg;
    assign meas_volt_fail   = meas_trip;
    assign supply_volt_fail = sup_trip;
    assign field_ovc_trip   = ovc_trip;
    assign rectifier_trip   = open_trip;
    assign excitation_stop  = open_trip;

    // Live state for software.
    assign status[ST_PHASE]   = phase_loss;
    assign status[ST_BLOCK]   = blocked;
    assign status[ST_ROUTE1]  = route1;
    assign status[ST_ROUTE2]  = route2;
    assign status[ST_ROUTE3]  = route3;
    assign status[ST_SUP_ACT] = supply_low;
    assign status[ST_MTRIP]   = meas_trip;
    assign status[ST_STRIP]   = sup_trip;
    assign status[ST_FCR]     = fcr_reg;
    assign status[ST_OVC]     = ovc_trip;
    assign status[ST_OPEN]    = open_trip;

    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    sequence s_zero_hold;
        (meas_low && cfg_reg[IDX_VDLY] == '0) [*2];
    endsequence

    property p_fcr_on_trip;
        (meas_trip || sup_trip) |=> fcr_reg;
    endproperty
    a_fcr_on_trip: assert property (p_fcr_on_trip)
        else $error("transfer not requested after voltage trip");

    property p_phase_loss;
        (phase_loss && sup_en && !blocked) |-> meas_low;
    endproperty
    a_phase_loss: assert property (p_phase_loss)
        else $error("phase loss not flagged as voltage failure");

    property p_block;
        blocked |-> !meas_low && !supply_low;
    endproperty
    a_block: assert property (p_block)
        else $error("supervision active during grid disturbance");

    property p_supply_gate;
        supply_low |-> sup_en && grid_on && v_diff > DIFF_MARGIN;
    endproperty
    a_supply_gate: assert property (p_supply_gate)
        else $error("supply supervision active without its conditions");

    property p_disable;
        !sup_en |=> !meas_trip && !sup_trip;
    endproperty
    a_disable: assert property (p_disable)
        else $error("voltage trip while supervision disabled");

    property p_zero_delay;
        s_zero_hold |-> meas_trip;
    endproperty
    a_zero_delay: assert property (p_zero_delay)
        else $error("zero delay did not trip on second cycle");

    property p_ovc;
        $rose(ovc_trip) |-> $past(ovc_cond) && $past(ifl_active);
    endproperty
    a_ovc: assert property (p_ovc)
        else $error("overcurrent trip without its condition");

    property p_open;
        open_trip |-> rectifier_trip && excitation_stop && $past(open_cond);
    endproperty
    a_open: assert property (p_open)
        else $error("open field trip without its condition");

    // The trip is registered, so it may still stand in the cycle of the drop.
    // One cycle later it must be gone, and a nonzero delay must run again.
    property p_restart;
        $fell(meas_low) |=> !meas_trip
            ##1 (!meas_trip || cfg_reg[IDX_VDLY] == '0);
    endproperty
    a_restart: assert property (p_restart)
        else $error("measuring trip survived a cleared condition");
endmodule

// File: test/evs_regulator_model.sv
// Behavioural model of the regulator and rectifier beyond the block.
`timescale 1ns/1ns
module evs_regulator_model
    import evs_pkg::*;
(
    input  wire logic                     aclk,
    input  wire logic                     transfer,
    input  wire logic                     rect_trip,
    input  wire logic signed [MEAS_W-1:0] field_set,
    input  wire logic signed [MEAS_W-1:0] ctrl_set,
    output logic                          in_fcr,
    output logic signed [MEAS_W-1:0]      field_current,
    output logic signed [MEAS_W-1:0]      control_signal
);
    // A rectifier trip drains the field, so the current reads zero after it.
    always_ff @(posedge aclk) begin
        in_fcr         <= transfer;
        field_current  <= rect_trip ? 16'sh0000 : field_set;
        control_signal <= ctrl_set;
    end
endmodule

// File: test/tb_evs_supervision.sv
// Self-checking bench for the excitation voltage supervision block.
`timescale 1ns/1ns
module tb_evs_supervision;
    import evs_pkg::*;
    logic aclk = 1'b0, aresetn = 1'b0, s_axi_bready = 1'b0;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, d;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic [1:0] s_axi_bresp, s_axi_rresp, r;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0;
    logic s_axi_rready = 1'b0, s_axi_awready, s_axi_wready, s_axi_bvalid;
    logic s_axi_arready, s_axi_rvalid, in_fcr;
    logic signed [15:0] u1 = 0, u2 = 0, us = 0, i1 = 0, i2 = 0, fs = 0, cs = 0;
    logic signed [15:0] field_current, control_signal;
    logic grid_on = 0, volt_synced = 0, exc_start = 0, ifl_active = 0;
    logic field_current_regulation_mode, mf, sf, field_ovc_trip, rectifier_trip, excitation_stop;
    int fail_count = 0, check_count = 0, cyc = 0;
    // Short tick keeps the delay scenarios to a few dozen cycles.
    evs_supervision #(.TICK_CYCLES(4)) dut (.aclk, .aresetn, .s_axi_awaddr,
        .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
        .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
        .positive_sequence_voltage(u1), .negative_sequence_voltage(u2),
        .supply_voltage(us), .pos_seq_current(i1), .neg_seq_current(i2),
        .field_current, .control_signal, .grid_on, .volt_synced, .exc_start,
        .ifl_active, .to_field_current_regulation_mode(field_current_regulation_mode),
        .meas_volt_fail(mf), .supply_volt_fail(sf), .field_ovc_trip,
        .rectifier_trip, .excitation_stop);
    evs_regulator_model far (.aclk, .transfer(field_current_regulation_mode), .rect_trip(rectifier_trip),
        .field_set(fs), .ctrl_set(cs), .in_fcr, .field_current,
        .control_signal);
    // Clock only; reset is released after 12 cycles in the main initial block.
    initial begin
        forever #5 aclk = ~aclk;
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            fail_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic step(input int n);
        repeat (n) @(posedge aclk);
    endtask
    // Both halves are offered together and each dropped once it is taken.
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge aclk);
        s_axi_awaddr <= a; s_axi_wdata <= v; s_axi_bready <= 1'b1;
        s_axi_awvalid <= 1'b1; s_axi_wvalid <= 1'b1;
        forever begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid) break;
        end
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge aclk);
        s_axi_araddr <= a; s_axi_arvalid <= 1'b1; s_axi_rready <= 1'b1;
        forever begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid) break;
        end
        d = s_axi_rdata; r = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask
    task automatic t_regs();
        logic [31:0] e [10] = '{32'h001, 32'h028, 32'h03c, 32'h03c, 32'h0c8,
            32'h064, 32'h258, 32'h258, 32'h064, 32'h00a};
        for (int k = 0; k < 10; k++) begin
            rd(8'(k * 4));
            chk(d, e[k]);
        end
        wr(8'h28, 32'h1);
        chk(32'(r), 32'(RESP_SLVERR));
        us <= -16'sd5;
        u1 <= 16'sd300;
        u2 <= -16'sd2;
        rd(8'h34);
        chk(d, 32'hfffffffb);
        rd(8'h2c);
        chk(d, 32'h0000012c);
        rd(8'h30);
        chk(d, 32'hfffffffe);
        rd(8'h3c);
        chk(32'(r), 32'(RESP_SLVERR));
    endtask
    task automatic t_meas();
        wr(8'h04, 32'h0);
        u1 <= 16'sd100; u2 <= 16'sd60; i1 <= 16'sd100; us <= 16'sd100;
        step(4);
        chk(mf, 1'b1);
        chk(field_current_regulation_mode, 1'b1);
        chk(in_fcr, 1'b1);
        i2 <= 16'sd60; step(4);
        chk(mf, 1'b0);
        u2 <= 16'sd40; i2 <= 16'sd0; volt_synced <= 1'b1; step(4);
        chk(mf, 1'b1);
        i2 <= 16'sd40;
        step(4);
        chk(mf, 1'b0);
        i2 <= 16'sd0;
        volt_synced <= 1'b0;
        step(4);
        chk(mf, 1'b0);
        u1 <= 16'sd5; u2 <= 16'sd0; us <= 16'sd5; exc_start <= 1'b1;
        fs <= 16'sd100; step(4);
        chk(mf, 1'b0);
        fs <= 16'sd101; step(4);
        chk(mf, 1'b1);
        exc_start <= 1'b0;
    endtask
    task automatic t_supply();
        u1 <= 16'sd100; us <= 16'sd70; grid_on <= 1'b1; step(4);
        chk(sf, 1'b1);
        wr(8'h00, 32'h0); step(2);
        chk(sf, 1'b0);
        wr(8'h00, 32'h1); us <= 16'sd130; step(4);
        chk(mf, 1'b1);
        grid_on <= 1'b0; step(4);
        chk(mf, 1'b0);
    endtask
    // Four ticks of four cycles; a short drop must restart the count.
    task automatic t_delay();
        wr(8'h04, 32'h4);
        u1 <= 16'sd100; us <= 16'sd100; u2 <= 16'sd60; step(10);
        chk(mf, 1'b0);
        u2 <= 16'sd0; step(2);
        u2 <= 16'sd60; step(10);
        chk(mf, 1'b0);
        step(15);
        chk(mf, 1'b1);
        u2 <= 16'sd0;
    endtask
    task automatic t_field();
        wr(8'h00, 32'h3); wr(8'h18, 32'h1);
        ifl_active <= 1'b1; cs <= 16'sd50; step(12);
        chk(field_ovc_trip, 1'b1);
        ifl_active <= 1'b0; step(3);
        chk(field_ovc_trip, 1'b0);
        wr(8'h00, 32'h5); wr(8'h1c, 32'h0);
        cs <= 16'sd150; fs <= 16'sd5; step(5);
        chk(rectifier_trip, 1'b1);
        chk(excitation_stop, 1'b1);
        cs <= 16'sd100; step(4);
        chk(rectifier_trip, 1'b0);
    endtask
    task automatic complete_run();
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    // A hung handshake is cut short well beyond the expected run length.
    always @(posedge aclk) begin
        cyc++;
        if (cyc == 20000) begin
            fail_count++;
            complete_run();
        end
    end
    initial begin
        step(12);
        aresetn <= 1'b1;
        t_regs(); t_meas(); t_supply(); t_delay(); t_field();
        complete_run();
    end
endmodule
